/* hdl/assc_pkg.sv */
// Package: register map, field layout and codes for the scan sequence control block
package assc_pkg;
  localparam logic [7:0]  SCAN_CTRL_OFFSET = 8'h10;
  localparam logic [31:0] SCAN_CTRL_RESET  = 32'h0000_0000;
  // Writable bits; bit 31, 27:25, 19, 7:6 and 3 are reserved
  localparam logic [31:0] SCAN_CTRL_MASK   = 32'h71F7_FF37;
  localparam int TRIG_SEL_LSB  = 28;
  localparam int TRIG_EN_BIT   = 24;
  localparam int ACQ_LSB       = 20;
  localparam int REF_LSB       = 16;
  localparam int CHMASK_LSB    = 8;
  localparam int RES_LSB       = 4;
  localparam int ALIGN_BIT     = 2;
  localparam int DIFFERENTIAL_INPUT_MODE_BIT      = 1;
  localparam int REP_BIT       = 0;
  localparam logic [3:0] ACQ_MAX_CODE = 4'h8;
  localparam logic [1:0] RES_12BIT = 2'h0;
  localparam logic [1:0] RES_8BIT  = 2'h1;
  localparam logic [1:0] RES_6BIT  = 2'h2;
  localparam logic [1:0] RES_OVS   = 2'h3;
  localparam logic [2:0] REF_1V25      = 3'h0;
  localparam logic [2:0] REF_2V5       = 3'h1;
  localparam logic [2:0] REF_SUPPLY    = 3'h2;
  localparam logic [2:0] REF_5VDIFF    = 3'h3;
  localparam logic [2:0] REF_EXTSINGLE = 3'h4;
  localparam logic [2:0] REF_2XEXTDIFF = 3'h5;
  localparam logic [2:0] REF_2XSUPPLY  = 3'h6;
  typedef enum logic [1:0] {
    ASSC_IDLE    = 2'b00,
    ASSC_ACQUIRE = 2'b01,
    ASSC_CONVERT = 2'b11
  } assc_state_e;
endpackage

/* hdl/assc_trig_sync.sv */
// Event channel synchroniser and start pulse for the scan sequence
`timescale 1ns/1ps
`default_nettype none
module assc_trig_sync (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic [7:0] eventIn,
  input  wire logic [2:0] channelSel,
  input  wire logic       trigEnable,
  output logic            startPulse
);
  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] level;
    logic       start;
  } assc_sync_s;
  assc_sync_s r;
  assc_sync_s next_r;
  always_comb
  begin
    next_r = r;
    next_r.s1 = eventIn;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    // Level only moves once stages two and three agree
    for (int i = 0; i < 8; i++)
    begin
      if (r.s2[i] == r.s3[i])
      begin
        next_r.level[i] = r.s3[i];
      end
    end
    // Rising edge of the chosen channel; disabled trigger never starts
    next_r.start = trigEnable && r.s3[channelSel] && !r.level[channelSel]
                   && (r.s2[channelSel] == r.s3[channelSel]); // see R1 see R2
  end
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end
  assign startPulse = r.start;
endmodule // assc_trig_sync
`default_nettype wire

/* hdl/assc_acq_timer.sv */
// Acquisition timer: counts 2**code converter clock cycles
`timescale 1ns/1ps
`default_nettype none
module assc_acq_timer (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       load,
  input  wire logic [3:0] acqCode,
  output logic            done
);
  typedef struct packed {
    logic [8:0] count;
    logic       busy;
    logic       done;
  } assc_tmr_s;
  assc_tmr_s r;
  assc_tmr_s next_r;
  logic [3:0] code;
  always_comb
  begin
    next_r = r;
    next_r.done = 1'b0;
    // Codes above 8 are clipped to the longest time
    code = (acqCode > assc_pkg::ACQ_MAX_CODE) ? assc_pkg::ACQ_MAX_CODE : acqCode;
    if (load)
    begin
      next_r.count = 9'(9'h001 << code) - 9'h001; // see R3
      next_r.busy = 1'b1;
    end
    else if (r.busy)
    begin
      if (r.count == 9'h000)
      begin
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
      end
      else
      begin
        next_r.count = r.count - 9'h001;
      end
    end
  end
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end
  assign done = r.done;
endmodule // assc_acq_timer
`default_nettype wire

/* hdl/assc_scan_ctrl.sv */
// Scan sequence control register, trigger and channel sequencer
//
// Behaviour
// R1 - Trigger channel field 30:28 picks which of eight event channels may start a scan.
// R2 - With trigger enable set an event on that channel starts a scan, otherwise none does.
// R3 - Acquisition field 23:20 gives 2**value converter clock cycles per sample, 1 to 256.
// R4 - Software writes zero to reserved bits 31, 27:25, 19, 7:6 and 3.
// R5 - Reference field 18:16 selects one of seven references, codes 0 to 6.
// R6 - Single ended, each set mask bit n includes input n; several may be set.
// R7 - Differential, mask bits 0 to 3 include pairs 0/1 to 6/7; upper nibble reserved.
// R8 - Resolution 0,1,2 give 12, 8, 6 bits; code 3 enables oversampling.
// R9 - Alignment bit 2 right aligns at 0 and left aligns at 1.
// R10 - Bit 1 selects differential inputs and the differential mask meaning.
// R11 - Repetitive bit 0 stops after one sequence at 0, repeats until a stop at 1.
// R12 - All fields reset to zero and read back as written, reserved bits as zero.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module assc_scan_ctrl (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdata,
  input  wire logic [7:0]  eventIn,
  input  wire logic        scanStart,
  input  wire logic        scanStopCommand,
  input  wire logic        convDone,
  output logic             convStart,
  output logic      [2:0]  convChannel,
  output logic             convDiff,
  output logic      [2:0]  convReference,
  output logic      [1:0]  convResolution,
  output logic             convOversample,
  output logic             resultAlignLeft,
  output logic             sampling,
  output logic             scanActive,
  output logic             sequenceDone
);
  typedef struct packed {
    logic [31:0]           ctrl;
    logic [31:0]           rdata;
    assc_pkg::assc_state_e state;
    logic [2:0]            chan;
    logic [7:0]            pending;
    logic                  convStart;
    logic                  sampling;
    logic                  seqDone;
    logic                  stopReq;
    logic                  ovs;
    logic                  active;
  } assc_ctrl_s;
  assc_ctrl_s r;
  assc_ctrl_s next_r;
  logic       trigStart;
  logic       acqDone;
  logic [7:0] effMask;
  logic [7:0] nextPending;
  logic [2:0] firstChan;
  logic       anyChan;
  logic       acqLoad;

  assc_trig_sync uSync (
    .mclk       (mclk),
    .nrst       (nrst),
    .eventIn    (eventIn),
    .channelSel (r.ctrl[assc_pkg::TRIG_SEL_LSB +: 3]),
    .trigEnable (r.ctrl[assc_pkg::TRIG_EN_BIT]),
    .startPulse (trigStart)
  );

  assc_acq_timer uTimer (
    .mclk    (mclk),
    .nrst    (nrst),
    .load    (acqLoad),
    .acqCode (r.ctrl[assc_pkg::ACQ_LSB +: 4]),
    .done    (acqDone)
  );

  // Differential mode only honours the low nibble; reserved patterns are ignored
  always_comb
  begin
    if (r.ctrl[assc_pkg::DIFFERENTIAL_INPUT_MODE_BIT])
    begin
      effMask = {4'h0, r.ctrl[assc_pkg::CHMASK_LSB +: 4]}; // see R7 see R10
    end
    else
    begin
      effMask = r.ctrl[assc_pkg::CHMASK_LSB +: 8]; // see R6
    end
  end

  // Lowest pending entry is sampled first
  always_comb
  begin
    firstChan = 3'h0;
    anyChan = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      if (r.pending[i])
      begin
        firstChan = 3'(i);
        anyChan = 1'b1;
      end
    end
  end

  assign acqLoad = next_r.sampling && !r.sampling;

  always_comb
  begin
    next_r = r;
    next_r.convStart = 1'b0;
    next_r.seqDone = 1'b0;
    nextPending = r.pending;
    // Register port; reserved bits are dropped so they read as zero
    if (regWrite && (regAddr == assc_pkg::SCAN_CTRL_OFFSET))
    begin
      next_r.ctrl = regWdata & assc_pkg::SCAN_CTRL_MASK; // see R4 see R12
    end
    next_r.rdata = 32'h0000_0000;
    if (regRead && (regAddr == assc_pkg::SCAN_CTRL_OFFSET))
    begin
      next_r.rdata = r.ctrl; // see R12
    end
    // A stop arriving mid scan is kept until the current conversion ends
    if (scanStopCommand && (r.state != assc_pkg::ASSC_IDLE))
    begin
      next_r.stopReq = 1'b1;
    end
    case (r.state)
      assc_pkg::ASSC_IDLE:
      begin
        next_r.stopReq = 1'b0;
        if ((trigStart || scanStart) && (effMask != 8'h00)) // see R2
        begin
          next_r.pending = effMask;
          next_r.state = assc_pkg::ASSC_ACQUIRE;
          next_r.sampling = 1'b1;
        end
      end
      assc_pkg::ASSC_ACQUIRE:
      begin
        next_r.chan = firstChan;
        if (!anyChan)
        begin
          // Nothing left to sample; fall back to idle rather than convert a stale channel
          next_r.sampling = 1'b0;
          next_r.state = assc_pkg::ASSC_IDLE;
        end
        else if (acqDone) // see R3
        begin
          next_r.sampling = 1'b0;
          next_r.convStart = 1'b1;
          next_r.state = assc_pkg::ASSC_CONVERT;
        end
      end
      assc_pkg::ASSC_CONVERT:
      begin
        if (convDone)
        begin
          nextPending[r.chan] = 1'b0;
          if (nextPending != 8'h00 && !next_r.stopReq)
          begin
            next_r.pending = nextPending;
            next_r.state = assc_pkg::ASSC_ACQUIRE;
            next_r.sampling = 1'b1;
          end
          else
          begin
            next_r.seqDone = 1'b1;
            // Repeat only when enabled, not stopped and something is still selected
            if (r.ctrl[assc_pkg::REP_BIT] && !next_r.stopReq && effMask != 8'h00) // see R11
            begin
              next_r.pending = effMask;
              next_r.state = assc_pkg::ASSC_ACQUIRE;
              next_r.sampling = 1'b1;
            end
            else
            begin
              next_r.pending = 8'h00;
              next_r.state = assc_pkg::ASSC_IDLE;
            end
          end
        end
      end
      default:
      begin
        next_r.state = assc_pkg::ASSC_IDLE;
        next_r.sampling = 1'b0;
      end
    endcase
    // Decodes are registered so the core never sees a settling glitch
    next_r.ovs = (next_r.ctrl[assc_pkg::RES_LSB +: 2] == assc_pkg::RES_OVS); // see R8
    next_r.active = (next_r.state != assc_pkg::ASSC_IDLE);
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      r <= '0;
      r.ctrl <= assc_pkg::SCAN_CTRL_RESET;
      r.state <= assc_pkg::ASSC_IDLE;
    end
    else
    begin
      r <= next_r;
    end
  end

  // Settings driven to the core are register bits, so outputs stay flopped
  assign regRdata        = r.rdata;
  assign convStart       = r.convStart;
  assign convChannel     = r.chan; // see R6 see R7
  assign convDiff        = r.ctrl[assc_pkg::DIFFERENTIAL_INPUT_MODE_BIT]; // see R10
  assign convReference   = r.ctrl[assc_pkg::REF_LSB +: 3]; // see R5
  assign convResolution  = r.ctrl[assc_pkg::RES_LSB +: 2]; // see R8
  assign convOversample  = r.ovs; // see R8
  assign resultAlignLeft = r.ctrl[assc_pkg::ALIGN_BIT]; // see R9
  assign sampling        = r.sampling;
  assign scanActive      = r.active;
  assign sequenceDone    = r.seqDone;
endmodule // assc_scan_ctrl
`default_nettype wire

/* tb/assc_conv_model.sv */
// Converter core model answering each conversion start
`timescale 1ns/1ps
`default_nettype none
module assc_conv_model (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic convStart,
  input  wire logic slow,
  output logic      convDone
);
  logic [3:0] cnt;
  // A slow core makes the sequencer wait on a pending conversion
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt <= 4'h0;
      convDone <= 1'b0;
    end
    else
    begin
      convDone <= cnt == 4'h1;
      if (convStart)
        cnt <= slow ? 4'h6 : 4'h2;
      else if (cnt != 4'h0)
        cnt <= cnt - 4'h1;
    end
  end
endmodule // assc_conv_model
`default_nettype wire

/* tb/assc_scan_ctrl_chk.sv */
// Assertion checker for the scan sequence control block
`timescale 1ns/1ps
`default_nettype none
module assc_scan_ctrl_chk (
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [31:0] regRdata,
  input wire logic        convStart,
  input wire logic [2:0]  convChannel,
  input wire logic        convDiff,
  input wire logic [2:0]  convReference,
  input wire logic [1:0]  convResolution,
  input wire logic        convOversample,
  input wire logic        resultAlignLeft,
  input wire logic        sampling,
  input wire logic        scanActive,
  input wire logic        sequenceDone
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire logic wrCtrl = regWrite && regAddr == assc_pkg::SCAN_CTRL_OFFSET;
  rd_idle_a: assert property (!$past(regRead) |-> regRdata == 32'h0)
    else $error("read data not idle");
  rd_resv_a: assert property (regRead |=> (regRdata & ~assc_pkg::SCAN_CTRL_MASK) == 32'h0)
    else $error("reserved bits read back");
  wr_ref_a: assert property (wrCtrl |=> convReference == $past(regWdata[18:16]))
    else $error("reference not taken");
  wr_mode_a: assert property (wrCtrl |=> convDiff == $past(regWdata[1])
    && resultAlignLeft == $past(regWdata[2]))
    else $error("mode bits not taken");
  ovs_dec_a: assert property (wrCtrl |=> convResolution == $past(regWdata[5:4])
    && convOversample == (&$past(regWdata[5:4])))
    else $error("resolution or oversampling not taken");
  differential_input_mode_pair_a: assert property (convStart && convDiff |-> convChannel < 3'h4)
    else $error("pair index out of range");
  acq_len_a: assert property ($rose(sampling) |-> ##[1:258] !sampling)
    else $error("acquisition too long");
  start_pulse_a: assert property (convStart |=> !convStart)
    else $error("start not a pulse");
  done_act_a: assert property (sequenceDone |-> $past(scanActive))
    else $error("done while idle");
  cover property (sequenceDone);
  cover property (convStart && convDiff);
  cover property ($rose(sampling));
endmodule // assc_scan_ctrl_chk
bind assc_scan_ctrl assc_scan_ctrl_chk chk (.mclk, .nrst, .regAddr, .regWdata, .regWrite,
  .regRead, .regRdata, .convStart, .convChannel, .convDiff, .convReference, .convResolution,
  .convOversample, .resultAlignLeft, .sampling, .scanActive, .sequenceDone);
`default_nettype wire

/* tb/test_adc_scan_sequence_control.sv */
// Testbench for the scan sequence control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
  $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module test_adc_scan_sequence_control;
  logic        mclk, nrst, regWrite, regRead, scanStart, scanStopCommand, convDone, slow;
  logic        convStart, convDiff, convOversample, resultAlignLeft, sampling;
  logic        scanActive, sequenceDone;
  logic [31:0] regWdata, regRdata, d;
  logic [7:0]  regAddr, eventIn, seen;
  logic [2:0]  convChannel, convReference;
  logic [1:0]  convResolution;
  int          n_errors = 0, cmp_count = 0, cyc = 0, nSamp;
  assc_scan_ctrl dut (.mclk, .nrst, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
    .eventIn, .scanStart, .scanStopCommand, .convDone, .convStart, .convChannel, .convDiff,
    .convReference, .convResolution, .convOversample, .resultAlignLeft, .sampling,
    .scanActive, .sequenceDone);
  assc_conv_model conv (.mclk, .nrst, .convStart, .slow, .convDone);
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    regAddr <= a;
    regWdata <= v;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    @(negedge mclk);
    d = regRdata;
    @(posedge mclk);
  endtask
  // Runs until the sequence ends, noting channels converted and sampling cycles
  task automatic scan(input logic go);
    seen = 8'h00;
    nSamp = 0;
    scanStart <= go;
    @(posedge mclk);
    scanStart <= 1'b0;
    repeat (3000)
    begin
      @(negedge mclk);
      nSamp += int'(sampling);
      if (convStart)
        seen[convChannel] = 1'b1;
      if (sequenceDone)
        break;
    end
    @(posedge mclk);
  endtask
  task automatic t_regs;
    rd(8'h10);
    `CHK(d, 32'h0000_0000)
    wr(8'h10, 32'h71F7_FF35);
    wr(8'h14, 32'h0000_0000);
    rd(8'h10);
    `CHK(d, 32'h71F7_FF35)
    rd(8'h14);
    `CHK(d, 32'h0000_0000)
    for (int i = 0; i < 7; i++)
    begin
      wr(8'h10, {13'h0, i[2:0], 10'h0, i[1:0], 1'b0, i[0], ~i[0], 1'b0});
      @(negedge mclk);
      `CHK({convReference, convResolution, convOversample}, {i[2:0], i[1:0], &i[1:0]})
      `CHK({resultAlignLeft, convDiff}, {i[0], ~i[0]})
      @(posedge mclk);
    end
    $display("test regs done");
  endtask
  task automatic t_seq;
    wr(8'h10, 32'h0030_A500);
    scan(1'b1);
    `CHK(seen, 8'hA5)
    `CHK(nSamp, 36)
    repeat (3) @(negedge mclk);
    `CHK(scanActive, 1'b0)
    @(posedge mclk);
    wr(8'h10, 32'h0000_0A02);
    scan(1'b1);
    `CHK(seen, 8'h0A)
    `CHK(nSamp, 4)
    $display("test sequence done");
  endtask
  task automatic t_trig;
    wr(8'h10, 32'h5180_0100);
    eventIn <= 8'h08;
    repeat (10) @(negedge mclk);
    `CHK(scanActive, 1'b0)
    @(posedge mclk);
    eventIn <= 8'h28;
    scan(1'b0);
    `CHK(seen, 8'h01)
    `CHK(nSamp, 257)
    wr(8'h10, 32'h5080_0100);
    eventIn <= 8'h00;
    repeat (4) @(posedge mclk);
    eventIn <= 8'h20;
    repeat (10) @(negedge mclk);
    `CHK(scanActive, 1'b0)
    @(posedge mclk);
    $display("test trigger done");
  endtask
  task automatic t_rep;
    slow <= 1'b1;
    wr(8'h10, 32'h0000_0301);
    scan(1'b1);
    scan(1'b0);
    `CHK(seen, 8'h03)
    scanStopCommand <= 1'b1;
    @(posedge mclk);
    scanStopCommand <= 1'b0;
    repeat (60) @(negedge mclk);
    `CHK(scanActive, 1'b0)
    $display("test repeat done");
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Cuts a hung sequence short
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      results;
    end
  end
  initial
  begin
    {nrst, regWrite, regRead, scanStart, scanStopCommand, slow} = 6'h00;
    {regWdata, regAddr, eventIn} = 48'h0;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    t_regs;
    t_seq;
    t_trig;
    t_rep;
    results;
  end
endmodule // test_adc_scan_sequence_control
`default_nettype wire
